// ===== tss_cfg.svh
// Register map, field positions, reset values and timing of the sensor status/config block
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

`define TSS_ADDR_TEMP_MSB 8'h00
`define TSS_ADDR_TEMP_LSB 8'h01
`define TSS_ADDR_STATUS 8'h02
`define TSS_ADDR_CONFIG 8'h03

`define TSS_ST_UNDER 4
`define TSS_ST_OVER 5
`define TSS_ST_CRIT 6
`define TSS_ST_RDY 7

`define TSS_CFG_FQ 1:0
`define TSS_CFG_CRIT_POL 2
`define TSS_CFG_INT_POL 3
`define TSS_CFG_CMP 4
`define TSS_CFG_MODE 6:5
`define TSS_CFG_RES 7
`define TSS_CFG_RESET 8'h00

`define TSS_HYST_SHIFT 7
`define TSS_CLK_KHZ 100000
`define TSS_SPS_PERIOD_MS 1000

`endif

// ===== tss_pkg.sv
// Types of the sensor status/config block
package tss_pkg;

    typedef enum logic [1:0] {
        TSS_MODE_CONT = 2'h0,
        TSS_MODE_ONE = 2'h1,
        TSS_MODE_SPS = 2'h2,
        TSS_MODE_OFF = 2'h3
    } tss_mode_t;

    typedef enum logic [1:0] {
        TSS_ST_IDLE = 2'b00,
        TSS_ST_CONV = 2'b01,
        TSS_ST_WAIT = 2'b11,
        TSS_ST_DOWN = 2'b10
    } tss_seq_t;

    typedef struct packed {
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic done_lvl;
        tss_seq_t seq;
        logic [26:0] timer;
        logic one_shot_req;
        logic [7:0] cfg;
        logic flag_under;
        logic flag_over;
        logic flag_crit;
        logic ready_n;
        logic [2:0] int_cnt;
        logic [2:0] crit_cnt;
        logic int_active;
        logic crit_active;
        logic [7:0] rd_data;
        logic conv_start;
        logic powerdown;
        logic int_oe;
        logic crit_oe;
    } tss_state_t;

endpackage : tss_pkg

// ===== tss_status_config.sv
// Status flags, configuration, conversion sequencing and alarm pins of the temperature sensor
`timescale 1ns/10ps
`include "tss_cfg.svh"

module tss_status_config import tss_pkg::*; #(
    parameter int unsigned SPS_PERIOD_CYC = `TSS_SPS_PERIOD_MS * `TSS_CLK_KHZ
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic conv_done_i,
    input wire logic [15:0] temp_value_i,
    input wire logic [15:0] high_limit_i,
    input wire logic [15:0] under_limit_i,
    input wire logic [15:0] critical_limit_i,
    input wire logic [3:0] hysteresis_value_i,
    output logic conv_start_o,
    output logic powerdown_o,
    output logic resolution_o,
    output logic limit_int_o,
    output logic limit_int_oe_o,
    output logic critical_alarm_out_o,
    output logic critical_alarm_out_oe_o
);

    // ==========================================================
    // State and working signals
    tss_state_t r;
    tss_state_t n;
    logic done_ev;
    logic rd_status;
    logic rd_temp;
    logic wr_config;
    logic signed [17:0] temp_s;
    logic signed [17:0] high_s;
    logic signed [17:0] low_s;
    logic signed [17:0] crit_s;
    logic signed [17:0] hyst_s;
    logic below_low;
    logic above_high;
    logic above_crit;
    logic under_back;
    logic over_back;
    logic crit_back;
    logic [2:0] fq_need;
    tss_mode_t mode;

    // ==========================================================
    // Limit comparison
    assign temp_s = {{2{temp_value_i[15]}}, temp_value_i};
    assign high_s = {{2{high_limit_i[15]}}, high_limit_i};
    assign low_s = {{2{under_limit_i[15]}}, under_limit_i};
    assign crit_s = {{2{critical_limit_i[15]}}, critical_limit_i};
    assign hyst_s = 18'(hysteresis_value_i) <<< `TSS_HYST_SHIFT;
    assign below_low = temp_s < low_s;
    assign above_high = temp_s > high_s;
    assign above_crit = temp_s > crit_s;
    assign under_back = temp_s > (low_s + hyst_s);
    assign over_back = temp_s < (high_s - hyst_s);
    assign crit_back = temp_s < (crit_s - hyst_s);

    assign mode = tss_mode_t'(r.cfg[`TSS_CFG_MODE]);
    assign fq_need = {1'b0, r.cfg[`TSS_CFG_FQ]} + 3'h1;

    assign rd_status = reg_rd_i && (reg_addr_i == `TSS_ADDR_STATUS);
    assign rd_temp = reg_rd_i && ((reg_addr_i == `TSS_ADDR_TEMP_MSB) || (reg_addr_i == `TSS_ADDR_TEMP_LSB));
    assign wr_config = reg_wr_i && (reg_addr_i == `TSS_ADDR_CONFIG);

    // ==========================================================
    // Next state
    always_comb begin
        n = r;
        done_ev = 1'b0;
        n.conv_start = 1'b0;

        // Conversion-done synchroniser and edge
        n.done_s1 = conv_done_i;
        n.done_s2 = r.done_s1;
        n.done_s3 = r.done_s2;
        if ((r.done_s2 == r.done_s3) && (r.done_s3 != r.done_lvl)) begin
            n.done_lvl = r.done_s3;
            done_ev = r.done_s3;
        end

        // Register writes
        if (wr_config) begin
            n.cfg = reg_wdata_i;
            if (tss_mode_t'(reg_wdata_i[`TSS_CFG_MODE]) == TSS_MODE_ONE) begin
                n.one_shot_req = 1'b1;
            end
            if ((tss_mode_t'(reg_wdata_i[`TSS_CFG_MODE]) == TSS_MODE_ONE) ||
                (tss_mode_t'(reg_wdata_i[`TSS_CFG_MODE]) == TSS_MODE_SPS)) begin
                n.ready_n = 1'b1;
            end
        end

        if (rd_temp) begin
            n.ready_n = 1'b1;
        end

        if (rd_status) begin
            n.flag_under = 1'b0;
            n.flag_over = 1'b0;
            n.flag_crit = 1'b0;
            // interrupt mode holds until status read
            if (!r.cfg[`TSS_CFG_CMP]) begin
                n.int_active = 1'b0;
                n.crit_active = 1'b0;
            end
        end

        // Result evaluation, sets win over clears
        if (done_ev) begin
            n.ready_n = 1'b0;
            if (under_back) begin
                n.flag_under = 1'b0;
            end
            if (over_back) begin
                n.flag_over = 1'b0;
            end
            if (crit_back) begin
                n.flag_crit = 1'b0;
            end
            if (below_low) begin
                n.flag_under = 1'b1;
            end
            if (above_high) begin
                n.flag_over = 1'b1;
            end
            if (above_crit) begin
                n.flag_crit = 1'b1;
            end

            if (below_low || above_high) begin
                if (r.int_cnt != 3'h4) begin
                    n.int_cnt = r.int_cnt + 3'h1;
                end
            end else begin
                n.int_cnt = 3'h0;
            end
            if (above_crit) begin
                if (r.crit_cnt != 3'h4) begin
                    n.crit_cnt = r.crit_cnt + 3'h1;
                end
            end else begin
                n.crit_cnt = 3'h0;
            end

            if (r.cfg[`TSS_CFG_CMP]) begin
                if (under_back && over_back) begin
                    n.int_active = 1'b0;
                end
                if (crit_back) begin
                    n.crit_active = 1'b0;
                end
            end
            if ((below_low || above_high) && (n.int_cnt >= fq_need)) begin
                n.int_active = 1'b1;
            end
            if (above_crit && (n.crit_cnt >= fq_need)) begin
                n.crit_active = 1'b1;
            end
        end

        // Conversion sequencer
        if (r.timer != 27'h7FFFFFF) begin
            n.timer = r.timer + 27'h1;
        end
        case (r.seq)
            TSS_ST_IDLE: begin
                case (mode)
                    TSS_MODE_CONT: begin
                        n.conv_start = 1'b1;
                        n.seq = TSS_ST_CONV;
                    end
                    TSS_MODE_ONE: begin
                        if (r.one_shot_req) begin
                            n.one_shot_req = 1'b0;
                            n.conv_start = 1'b1;
                            n.seq = TSS_ST_CONV;
                        end
                    end
                    TSS_MODE_SPS: begin
                        n.conv_start = 1'b1;
                        n.timer = 27'h0;
                        n.seq = TSS_ST_CONV;
                    end
                    default: begin
                        n.seq = TSS_ST_DOWN;
                    end
                endcase
            end
            TSS_ST_CONV: begin
                if (mode == TSS_MODE_OFF) begin
                    n.seq = TSS_ST_DOWN;
                end else if (done_ev) begin
                    n.seq = (mode == TSS_MODE_SPS) ? TSS_ST_WAIT : TSS_ST_IDLE;
                end
            end
            TSS_ST_WAIT: begin
                if ((mode != TSS_MODE_SPS) || (r.timer >= 27'(SPS_PERIOD_CYC - 1))) begin
                    n.seq = TSS_ST_IDLE;
                end
            end
            TSS_ST_DOWN: begin
                if (mode != TSS_MODE_OFF) begin
                    n.seq = TSS_ST_IDLE;
                end
            end
            default: begin
                n.seq = TSS_ST_IDLE;
            end
        endcase
        n.powerdown = (n.seq == TSS_ST_DOWN);

        // limit interrupt and critical alarm polarity, open drain pulls low
        n.int_oe = n.cfg[`TSS_CFG_INT_POL] ? !n.int_active : n.int_active;
        n.crit_oe = n.cfg[`TSS_CFG_CRIT_POL] ? !n.crit_active : n.crit_active;

        // Read data
        if (reg_rd_i) begin
            case (reg_addr_i)
                `TSS_ADDR_STATUS: n.rd_data = {n.ready_n, r.flag_crit, r.flag_over, r.flag_under, 4'h0};
                `TSS_ADDR_CONFIG: n.rd_data = r.cfg;
                default: n.rd_data = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r <= '0;
            r.cfg <= `TSS_CFG_RESET;
            r.ready_n <= 1'b1;
        end else if (ce_i) begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_o = r.rd_data;
    assign conv_start_o = r.conv_start;
    assign powerdown_o = r.powerdown;
    assign resolution_o = r.cfg[`TSS_CFG_RES];
    // mode select acts through int_active and crit_active
    assign limit_int_o = r.powerdown & 1'b0;
    assign limit_int_oe_o = r.int_oe;
    assign critical_alarm_out_o = r.powerdown & 1'b0;
    assign critical_alarm_out_oe_o = r.crit_oe;

endmodule : tss_status_config

// ===== tss_status_config_assertions.sv
// Concurrent checks on the sensor status and config ports
`timescale 1ns/10ps
`include "tss_cfg.svh"
module tss_status_config_checker #(
    parameter int unsigned SPS_PERIOD_CYC = 200
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic conv_done_i,
    input wire logic conv_start_o,
    input wire logic powerdown_o,
    input wire logic resolution_o,
    input wire logic limit_int_oe_o,
    input wire logic critical_alarm_out_oe_o
);
    // ====================
    // Config mirror
    logic [7:0] cfg_q;
    logic [1:0] cfg_age;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= 8'h00;
            cfg_age <= 2'h0;
        end else if (ce_i && reg_wr_i && reg_addr_i == `TSS_ADDR_CONFIG) begin
            cfg_q <= reg_wdata_i;
            cfg_age <= 2'h0;
        end else if (cfg_age != 2'h3) begin
            cfg_age <= cfg_age + 2'h1;
        end
    end
    // ====================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence stat_rd;
        reg_rd_i && reg_addr_i == `TSS_ADDR_STATUS;
    endsequence
    sequence temp_rd;
        reg_rd_i && reg_addr_i == `TSS_ADDR_TEMP_MSB;
    endsequence
    status_low_zero_a: assert property (stat_rd |=> reg_rdata_o[3:0] == 4'h0)
        else $error("status low bits set");
    unmapped_read_a: assert property (reg_rd_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    cfg_readback_a: assert property (reg_rd_i && reg_addr_i == `TSS_ADDR_CONFIG |=> reg_rdata_o == cfg_q)
        else $error("config readback wrong");
    cfg_outputs_a: assert property (cfg_age == 2'h3 |-> resolution_o == cfg_q[7] && powerdown_o == (cfg_q[6:5] == 2'h3))
        else $error("resolution or powerdown wrong");
    no_start_off_a: assert property (cfg_age == 2'h3 && cfg_q[6:5] == 2'h3 |-> !conv_start_o)
        else $error("start in shutdown");
    start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("start longer than one cycle");
    cont_restart_a: assert property ($rose(conv_done_i) && cfg_q[6:5] == 2'h0 && cfg_age == 2'h3 |-> ##[2:8] conv_start_o)
        else $error("continuous restart missing");
    one_shot_a: assert property (reg_wr_i && reg_addr_i == `TSS_ADDR_CONFIG && reg_wdata_i[6:5] == 2'h1 |-> ##[1:4] conv_start_o)
        else $error("one shot start missing");
    int_read_clear_a: assert property (stat_rd and !cfg_q[4] && cfg_age == 2'h3
        |-> ##2 limit_int_oe_o == cfg_q[3] && critical_alarm_out_oe_o == cfg_q[2])
        else $error("alarm not released by status read");
    ready_release_a: assert property (temp_rd ##[1:4] stat_rd |=> reg_rdata_o[7])
        else $error("ready not released");
endmodule : tss_status_config_checker

// ===== tss_conv_model.sv
// Converter model answering start pulses on a slow link clock
`timescale 1ns/10ps
module tss_conv_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic conv_start_i,
    output logic conv_done_o
);
    logic link_clk = 1'b0;
    logic req = 1'b0;
    logic [2:0] cnt = 3'h0;
    always #62.5 link_clk = ~link_clk;
    always @(posedge clk_i) begin
        if (!rst_n_i || cnt == 3'h5) begin
            req <= 1'b0;
        end else if (conv_start_i) begin
            req <= 1'b1;
        end
    end
    // Result level low between frames
    always @(posedge link_clk) begin
        if (cnt == 3'h0 && req) begin
            cnt <= 3'h5;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
    assign conv_done_o = (cnt == 3'h2) || (cnt == 3'h1);
endmodule : tss_conv_model

// ===== test_tss_status_config.sv
// Self-checking bench of the sensor status and config block
`timescale 1ns/10ps
`include "tss_cfg.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module test_tss_status_config;
    localparam int SPS = 200;
    localparam logic [33:0] ROWS [7] = '{{8'h20, 16'h0F00, 8'h00, 2'b00}, {8'h20, 16'hF600, 8'h10, 2'b10},
        {8'h28, 16'h2300, 8'h20, 2'b00}, {8'h2C, 16'h0F00, 8'h00, 2'b11}, {8'h24, 16'h3C00, 8'h60, 2'b10},
        {8'h30, 16'h3C00, 8'h60, 2'b11}, {8'hB0, 16'h0F00, 8'h00, 2'b00}};
    localparam logic [17:0] HY [9] = '{{16'h2300, 2'b10}, {16'h1F00, 2'b10}, {16'h1B80, 2'b00},
        {16'hF600, 2'b10}, {16'h0600, 2'b10}, {16'h0A00, 2'b00}, {16'h3C00, 2'b11}, {16'h3000, 2'b11},
        {16'h2E00, 2'b10}};
    int n_mismatch = 0;
    int n_compared = 0;
    int n;
    logic [7:0] d;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [15:0] temp_value_i = 16'h0F00;
    logic [15:0] high_limit_i = 16'h2000;
    logic [15:0] under_limit_i = 16'h0500;
    logic [15:0] critical_limit_i = 16'h3200;
    logic [3:0] hysteresis_value_i = 4'h5;
    logic [7:0] reg_rdata_o;
    logic conv_done_i, conv_start_o, powerdown_o, resolution_o;
    logic limit_int_o, limit_int_oe_o, critical_alarm_out_o, critical_alarm_out_oe_o;
    tss_status_config #(.SPS_PERIOD_CYC(SPS)) u_dut (.*);
    tss_conv_model u_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .conv_start_i(conv_start_o), .conv_done_o(conv_done_i));
    always #5 clk_i = ~clk_i;
    // ====================
    // Bus tasks
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        v = reg_rdata_o;
    endtask : reg_rd
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : reg_wr
    task automatic conv(input logic [7:0] c, input logic [15:0] t);
        logic [7:0] v;
        temp_value_i <= t;
        reg_wr(`TSS_ADDR_CONFIG, c);
        reg_rd(`TSS_ADDR_STATUS, v);
        `CHK("ready_on_mode_write", 1'b1, v[7])
        for (int i = 0; i < 300 && conv_done_i !== 1'b1; i++) @(posedge clk_i);
        for (int i = 0; i < 300 && conv_done_i !== 1'b0; i++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask : conv
    task automatic count_starts(input logic [7:0] c, output int k);
        reg_wr(`TSS_ADDR_CONFIG, c);
        k = 0;
        repeat (1000) begin
            @(posedge clk_i);
            k += conv_start_o;
        end
    endtask : count_starts
    task automatic complete_run();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end
    // ====================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        reg_rd(`TSS_ADDR_STATUS, d);
        `CHK("rst_status", 8'h80, d)
        reg_rd(`TSS_ADDR_CONFIG, d);
        `CHK("rst_config", `TSS_CFG_RESET, d)
        reg_wr(`TSS_ADDR_CONFIG, 8'h60);
        @(posedge clk_i);
        `CHK("powerdown", 1'b1, powerdown_o)
        repeat (80) @(posedge clk_i);
        foreach (ROWS[k]) begin
            conv(ROWS[k][33:26], ROWS[k][25:10]);
            `CHK("int_oe", ROWS[k][1], limit_int_oe_o)
            `CHK("crit_oe", ROWS[k][0], critical_alarm_out_oe_o)
            `CHK("resolution", ROWS[k][33], resolution_o)
            reg_rd(`TSS_ADDR_STATUS, d);
            `CHK("status", ROWS[k][9:2], d)
        end
        reg_rd(`TSS_ADDR_TEMP_MSB, d);
        reg_rd(`TSS_ADDR_STATUS, d);
        `CHK("ready_release", 1'b1, d[7])
        reg_wr(8'h10, 8'hFF);
        reg_rd(8'h10, d);
        `CHK("unmapped", 8'h00, d)
        reg_rd(`TSS_ADDR_CONFIG, d);
        `CHK("config_keep", 8'hB0, d)
        ce_i <= 1'b0;
        reg_wr(`TSS_ADDR_CONFIG, 8'h00);
        ce_i <= 1'b1;
        reg_rd(`TSS_ADDR_CONFIG, d);
        `CHK("ce_freeze", 8'hB0, d)
        foreach (HY[k]) begin
            conv(8'h30, HY[k][17:2]);
            `CHK("hyst_int", HY[k][1], limit_int_oe_o)
            `CHK("hyst_crit", HY[k][0], critical_alarm_out_oe_o)
        end
        for (int q = 0; q < 4; q++) begin
            conv({6'h08, q[1:0]}, 16'h0F00);
            for (int f = 0; f <= q; f++) begin
                conv({6'h08, q[1:0]}, 16'h2300);
                `CHK("fault_queue", f == q, limit_int_oe_o)
            end
        end
        count_starts(8'h00, n);
        `CHK("continuous", 1'b1, n > 8)
        count_starts(8'h40, n);
        `CHK("one_per_second", 1'b1, n >= 3 && n <= 6)
        count_starts(8'h60, n);
        `CHK("shutdown", 0, n)
        complete_run();
    end
endmodule : test_tss_status_config
bind tss_status_config tss_status_config_checker #(.SPS_PERIOD_CYC(SPS_PERIOD_CYC)) u_chk (.*);
